// >>> core/tsc_top.v
// Purpose: tacho pulse capture with glitch filter, adaptive prescaler
//   and speed-sensor fault detection
// Assumes: one clock clk_i, synchronous active-high reset rst_i
// Notes: registers over classic Wishbone, ack one cycle after the request;
//   tacho pins are asynchronous and pass two flip-flops before the filter;
//   pulses_per_revolution is stored only, for software speed conversion;
//   a result counts prescaled ticks over pulses_per_average rising edges
//
// How it works
// - Filter counts agreeing samples of a new level, passes it after N.
// - Code 0 bypasses; codes 1-3 sample at full clock, N = 2, 4, 8.
// - Codes 4-9 sample at clock/2, /4, /8; N = 6 then 8.
// - Codes 10-12 at clock/16, 13-15 at clock/32; N = 5, 6, 8.
// - Timer counts to reload then wraps; each wrap is one overflow.
// - Prescaler picked from measured period and reload, next power of two.
// - Too many overflows before an average completes raise the sensor fault.
// - Prescaler picks and steps stay within the ceiling; a lowered ceiling applies at the next pick.
// - Update period is prescaler over core clock times reload plus one.
// - Core clock is one of two rates; filter time scales with it.
// - Higher rate selects external oscillator and one flash wait state.
//
// Added by the designer: the Wishbone slave port and the address map.
`include "tsc_regs.vh"
`default_nettype none

module tsc_top (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [3:0] tacho_i,
	output wire speed_sensor_fault_o,
	output wire result_valid_o,
	output wire osc_external_o,
	output wire flash_wait_state_o
);

	// ==========================================================
	// Helper functions
	// Sample divider exponent for a filter code
	function [2:0] flt_div;
		input [3:0] code;
		begin
			if (code <= 4'h3)
				flt_div = 3'd0;
			else if (code <= 4'h9)
				flt_div = code[3:1] - 3'd1;
			else if (code <= 4'hC)
				flt_div = 3'd4;
			else
				flt_div = 3'd5;
		end
	endfunction

	// Number of agreeing samples for a filter code
	function [3:0] flt_len;
		input [3:0] code;
		begin
			case (code)
				4'h1: flt_len = 4'h2;
				4'h2: flt_len = 4'h4;
				4'h3: flt_len = 4'h8;
				4'h4, 4'h6, 4'h8: flt_len = 4'h6;
				4'h5, 4'h7, 4'h9: flt_len = 4'h8;
				4'hA, 4'hD: flt_len = 4'h5;
				4'hB, 4'hE: flt_len = 4'h6;
				4'hC, 4'hF: flt_len = 4'h8;
				default: flt_len = 4'h1;
			endcase
		end
	endfunction

	// Smallest exponent e with reload << e covering the core-cycle count
	// Searched upwards so the first fit wins; clamped to the ceiling last
	function [3:0] psc_pick;
		input [47:0] cycles;
		input [15:0] reload;
		input [3:0] ceil;
		integer k;
		reg [3:0] e;
		reg found;
		begin
			e = ceil;
			found = 1'b0;
			for (k = 0; k < 16; k = k + 1) begin
				if (!found && ({32'h0, reload} << k) >= cycles) begin
					e = k[3:0];
					found = 1'b1;
				end
			end
			if (e > ceil)
				e = ceil;
			psc_pick = e;
		end
	endfunction

	// ==========================================================
	// Register file
	reg [7:0] ctrl_q;
	reg [15:0] reload_q;
	reg [7:0] avg_q;
	reg [7:0] ppr_q;
	reg [7:0] maxerr_q;
	reg [3:0] ceil_q;
	reg fault_q;
	reg valid_q;
	reg [31:0] period_q;
	reg [15:0] capt_q;
	reg [3:0] psc_q;
	reg [7:0] ovf_q;

	// A request is taken once: ack follows one cycle later and masks the
	// still-held strobe, so one access is never answered twice
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;
	wire wr_ctrl = wb_wr & (wb_adr_i == `TSC_ADR_CTRL) & wb_sel_i[0];
	wire wr_stat = wb_wr & (wb_adr_i == `TSC_ADR_STAT) & wb_sel_i[0];

	// Control fields
	wire en = ctrl_q[`TSC_CTRL_EN];
	wire [1:0] ch_sel = ctrl_q[`TSC_CTRL_CH_HI:`TSC_CTRL_CH_LO];
	wire [3:0] flt_code = ctrl_q[`TSC_CTRL_FLT_HI:`TSC_CTRL_FLT_LO];

	// Higher core rate needs the crystal and a flash wait state
	assign osc_external_o = ctrl_q[`TSC_CTRL_CLK];
	assign flash_wait_state_o = ctrl_q[`TSC_CTRL_CLK];
	assign speed_sensor_fault_o = fault_q;
	assign result_valid_o = valid_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl_q <= `TSC_RST_CTRL;
			reload_q <= `TSC_RST_RELOAD;
			avg_q <= `TSC_RST_AVG;
			ppr_q <= `TSC_RST_PPR;
			maxerr_q <= `TSC_RST_MAXERR;
			ceil_q <= `TSC_RST_CEIL;
		end else begin
			wb_ack_o <= wb_req;
			if (wr_ctrl)
				ctrl_q <= wb_dat_i[7:0];
			if (wb_wr && wb_adr_i == `TSC_ADR_RELOAD) begin
				if (wb_sel_i[0])
					reload_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					reload_q[15:8] <= wb_dat_i[15:8];
			end
			if (wb_wr && wb_adr_i == `TSC_ADR_AVG) begin
				if (wb_sel_i[0])
					avg_q <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					ppr_q <= wb_dat_i[15:8];
				if (wb_sel_i[2])
					maxerr_q <= wb_dat_i[23:16];
			end
			if (wb_wr && wb_adr_i == `TSC_ADR_CEIL && wb_sel_i[0])
				ceil_q <= wb_dat_i[3:0];
			// Read data stands only in the ack cycle and is zero otherwise
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`TSC_ADR_CTRL: wb_dat_o <= {24'h0, ctrl_q};
					`TSC_ADR_RELOAD: wb_dat_o <= {16'h0, reload_q};
					`TSC_ADR_AVG: wb_dat_o <= {8'h0, maxerr_q, ppr_q, avg_q};
					`TSC_ADR_CEIL: wb_dat_o <= {28'h0, ceil_q};
					`TSC_ADR_STAT: wb_dat_o <= {8'h0, ovf_q, 4'h0, psc_q,
						6'h0, valid_q, fault_q};
					`TSC_ADR_PERIOD: wb_dat_o <= period_q;
					`TSC_ADR_CAPT: wb_dat_o <= {16'h0, capt_q};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Input synchroniser and channel select
	reg [3:0] sync1_q;
	reg [3:0] sync2_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= tacho_i;
			sync2_q <= sync1_q;
		end
	end

	// Only the second stage feeds logic; all four pins share the stages
	wire tach_in = sync2_q[ch_sel];

	// ==========================================================
	// Glitch filter
	reg [4:0] smp_div_q;
	reg [3:0] agree_q;
	reg filt_q;
	reg filt_prev_q;
	reg [1:0] ch_prev_q;

	// Free-running divider; the mask picks the sample rate of the code
	wire [2:0] div_exp = flt_div(flt_code);
	wire [4:0] div_mask = (5'h01 << div_exp) - 5'h01;
	// Sample strobe at core clock divided by 2^div_exp
	wire smp_tick = ((smp_div_q & div_mask) == 5'h00);
	wire [3:0] need = flt_len(flt_code);

	// A channel switch reloads the filter from the new pin without an edge,
	// so reselecting the input never counts a pulse that did not happen
	wire ch_move = (ch_sel != ch_prev_q);

	// A sample equal to the passed level restarts the count: a glitch
	// shorter than the selected number of samples never gets through

	always @(posedge clk_i) begin
		if (rst_i) begin
			smp_div_q <= 5'h00;
			agree_q <= 4'h0;
			filt_q <= 1'b0;
			filt_prev_q <= 1'b0;
			ch_prev_q <= 2'h0;
		end else begin
			smp_div_q <= smp_div_q + 5'h01;
			filt_prev_q <= filt_q;
			ch_prev_q <= ch_sel;
			if (ch_move) begin
				filt_q <= tach_in;
				filt_prev_q <= tach_in;
				agree_q <= 4'h0;
			end else if (flt_code == 4'h0) begin
				filt_q <= tach_in;
				agree_q <= 4'h0;
			end else if (smp_tick) begin
				if (tach_in == filt_q) begin
					agree_q <= 4'h0;
				end else if (agree_q + 4'h1 >= need) begin
					filt_q <= tach_in;
					agree_q <= 4'h0;
				end else begin
					agree_q <= agree_q + 4'h1;
				end
			end
		end
	end

	// Only rising filtered edges are counted and captured
	wire edge_rise = filt_q & ~filt_prev_q;

	// ==========================================================
	// Prescaled timer, averaging, fault
	reg [15:0] psc_cnt_q;
	reg [15:0] tmr_q;
	reg [7:0] pulses_q;
	reg [31:0] acc_q;

	// One tick every 2^psc core cycles; the timer wraps after reload + 1 ticks
	wire [15:0] psc_top = (16'h0001 << psc_q) - 16'h0001;
	wire tick = en & (psc_cnt_q >= psc_top);
	wire wrap = tick & (tmr_q >= reload_q);
	// An average ends on the rising edge that completes the pulse count
	wire avg_done = en & edge_rise & (pulses_q + 8'h01 >= avg_q);
	// The wrap that reaches the overflow limit raises the fault
	wire ovf_limit = wrap & (ovf_q + 8'h01 >= maxerr_q);
	// The tick of the completing cycle belongs to the finished average;
	// leaving it out would make a result one tick short whenever that cycle ticks
	wire [31:0] acc_end = (tick && acc_q != 32'hFFFF_FFFF) ? acc_q + 32'h0000_0001 : acc_q;
	// Core cycles spent on the finished average
	wire [47:0] avg_cycles = {16'h0, acc_end} << psc_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			psc_cnt_q <= 16'h0000;
			tmr_q <= 16'h0000;
			pulses_q <= 8'h00;
			acc_q <= 32'h0000_0000;
			ovf_q <= 8'h00;
			psc_q <= `TSC_RST_PSC;
			period_q <= 32'h0000_0000;
			capt_q <= 16'h0000;
			fault_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			// Timer ticks once per 2^psc core cycles
			if (!en || tick)
				psc_cnt_q <= 16'h0000;
			else
				psc_cnt_q <= psc_cnt_q + 16'h0001;
			if (!en)
				tmr_q <= 16'h0000;
			else if (wrap)
				tmr_q <= 16'h0000;
			else if (tick)
				tmr_q <= tmr_q + 16'h0001;
			if (tick && acc_q != 32'hFFFF_FFFF)
				acc_q <= acc_q + 32'h0000_0001;
			if (en && edge_rise)
				capt_q <= tmr_q;
			// Disabling clears the counters but keeps the prescaler for a quick restart
			if (!en) begin
				pulses_q <= 8'h00;
				acc_q <= 32'h0000_0000;
				ovf_q <= 8'h00;
			end else if (avg_done) begin
				period_q <= acc_end;
				pulses_q <= 8'h00;
				acc_q <= 32'h0000_0000;
				ovf_q <= 8'h00;
				psc_q <= psc_pick(avg_cycles, reload_q, ceil_q);
			end else begin
				if (edge_rise)
					pulses_q <= pulses_q + 8'h01;
				// Overflow count saturates; only reaching the limit matters
				if (wrap && ovf_q != 8'hFF)
					ovf_q <= ovf_q + 8'h01;
			end
			// Slow rotor: step the prescaler up, bounded by the ceiling
			if (en && ovf_limit && !avg_done) begin
				ovf_q <= 8'h00;
				if (psc_q < ceil_q)
					psc_q <= psc_q + 4'h1;
			end
			// Write one clears; a new event in the same cycle wins
			if (wr_stat && wb_dat_i[`TSC_STAT_FAULT])
				fault_q <= 1'b0;
			if (en && ovf_limit && !avg_done)
				fault_q <= 1'b1;
			if (wr_stat && wb_dat_i[`TSC_STAT_VALID])
				valid_q <= 1'b0;
			if (avg_done)
				valid_q <= 1'b1;
		end
	end

endmodule // tsc_top

`default_nettype wire

// >>> core/tsc_regs.vh
// Purpose: register map and field layout of the tacho speed capture block
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: definitions only
`ifndef TSC_REGS_VH
`define TSC_REGS_VH

`define TSC_ADR_CTRL 8'h00
`define TSC_ADR_RELOAD 8'h04
`define TSC_ADR_AVG 8'h08
`define TSC_ADR_CEIL 8'h0C
`define TSC_ADR_STAT 8'h10
`define TSC_ADR_PERIOD 8'h14
`define TSC_ADR_CAPT 8'h18

// CTRL fields
`define TSC_CTRL_EN 0
`define TSC_CTRL_CLK 1
`define TSC_CTRL_CH_LO 2
`define TSC_CTRL_CH_HI 3
`define TSC_CTRL_FLT_LO 4
`define TSC_CTRL_FLT_HI 7
// STAT fields
`define TSC_STAT_FAULT 0
`define TSC_STAT_VALID 1

`define TSC_RST_CTRL 8'h00
`define TSC_RST_RELOAD 16'hFFFF
`define TSC_RST_AVG 8'h04
`define TSC_RST_PPR 8'h01
`define TSC_RST_MAXERR 8'h04
`define TSC_RST_CEIL 4'hF
`define TSC_RST_PSC 4'h0

`endif

// >>> dv/tsc_monitor.sv
// Purpose: bus and status checks on tsc_top
// Assumes: one clock, synchronous reset
// Notes: bound at the foot of this file
`default_nettype none
module tsc_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic speed_sensor_fault_o,
	input wire logic result_valid_o,
	input wire logic osc_external_o,
	input wire logic flash_wait_state_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_wr(logic [7:0] a); wb_ack_o && wb_we_i && wb_adr_i == a; endsequence
	a_ack_next: assert property (s_take |=> wb_ack_o) else $error("late ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_dat_quiet: assert property (!wb_ack_o |-> !wb_dat_o) else $error("stray data");
	a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1C |-> !wb_dat_o)
		else $error("hole not zero");
	a_osc_pair: assert property (osc_external_o == flash_wait_state_o)
		else $error("osc and wait differ");
	a_osc_write: assert property ($changed(osc_external_o) |-> s_wr(8'h00))
		else $error("clock choice moved");
	a_fault_w1c: assert property ($fell(speed_sensor_fault_o) |-> s_wr(8'h10))
		else $error("fault dropped");
	a_valid_w1c: assert property ($fell(result_valid_o) |-> s_wr(8'h10))
		else $error("valid dropped");
endmodule // tsc_monitor
bind tsc_top tsc_monitor i_tsc_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .speed_sensor_fault_o(speed_sensor_fault_o),
	.result_valid_o(result_valid_o), .osc_external_o(osc_external_o),
	.flash_wait_state_o(flash_wait_state_o));
`default_nettype wire

// >>> dv/tsc_tacho_model.sv
// Purpose: tacho sensor pulse source
// Assumes: half period of at least one cycle
// Notes: unselected pins toggle every cycle
`default_nettype none
module tsc_tacho_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [1:0] chan_i,
	input wire logic [15:0] half_i,
	output logic [3:0] tacho_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_q = 16'h0;
	logic lvl_q = 1'h0;
	logic junk_q = 1'h0;
	// ========================================
	// Each level lasts half_i cycles
	always_ff @(posedge clk_i) begin
		junk_q <= !junk_q;
		if (!run_i || cnt_q + 16'h1 >= half_i) begin
			cnt_q <= 16'h0;
		end else begin
			cnt_q <= cnt_q + 16'h1;
		end
		lvl_q <= run_i && (lvl_q ^ (cnt_q + 16'h1 >= half_i));
	end
	always_comb begin
		tacho_o = {4{junk_q}};
		tacho_o[chan_i] = lvl_q;
	end
endmodule // tsc_tacho_model
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: self-checking bench for tsc_top
// Assumes: monitor and pulse model compiled first
// Notes: first pulse length, channel and clock choice drawn from a fixed seed; filter-test pulse lengths computed
`include "tsc_regs.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, run = 0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'h0, tacho;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
	logic [15:0] half_q = 16'h1;
	logic [1:0] chan_q = 2'h0;
	logic wb_ack_o, fault, valid, osc, fws;
	int num_errors = 0, comparisons = 0, seed = 57, cyc = 0, h;
	int nt[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
	int dv[16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};
	tsc_top i_tsc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tacho_i(tacho), .speed_sensor_fault_o(fault),
		.result_valid_o(valid), .osc_external_o(osc), .flash_wait_state_o(fws));
	tsc_tacho_model i_tsc_tacho_model (.clk_i(clk_i), .run_i(run), .chan_i(chan_q),
		.half_i(half_q), .tacho_o(tacho));
	// ========================================
	// Clock, timeout, helpers
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		// Wait for ack however long; only the run's own timeout ends a hang
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'h1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic wv(input int lim);
		int k = 0;
		while (valid !== 1'h1 && k < lim) begin
			@(posedge clk_i);
			k++;
		end
	endtask
	task automatic cfg(input logic [3:0] code, input logic [3:0] cl);
		logic [1:0] ch = $random(seed);
		logic ck = $random(seed);
		chan_q <= ch;
		wb(1'h1, `TSC_ADR_CTRL, 32'h0);
		wb(1'h1, `TSC_ADR_STAT, 32'h3);
		wb(1'h1, `TSC_ADR_CEIL, {28'h0, cl});
		wb(1'h1, `TSC_ADR_CTRL, {24'h0, code, ch, ck, 1'h1});
		@(posedge clk_i);
		chk(osc, ck);
		chk(fws, ck);
	endtask
	function automatic int epsc(input int cycles, input int rl, input int cl);
		int e = 0;
		while ((rl << e) < cycles && e < cl) e++;
		return e;
	endfunction
	// ========================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(`TSC_ADR_CTRL, 32'h0);
		rd(`TSC_ADR_RELOAD, 32'hFFFF);
		rd(`TSC_ADR_AVG, 32'h00040104);
		rd(`TSC_ADR_CEIL, 32'hF);
		rd(`TSC_ADR_STAT, 32'h0);
		rd(8'h1C, 32'h0);
		h = $random(seed);
		wb(1'h1, `TSC_ADR_RELOAD, h);
		rd(`TSC_ADR_RELOAD, {16'h0, h[15:0]});
		wb(1'h1, `TSC_ADR_RELOAD, 32'hFF);
		wb(1'h1, `TSC_ADR_AVG, 32'h00FF0104);
		h = 20 + ($random(seed) & 31);
		half_q <= h;
		run <= 1'h1;
		cfg(4'h0, 4'h0);
		wv(40 * h);
		wb(1'h1, `TSC_ADR_STAT, 32'h2);
		wv(20 * h);
		chk(valid, 1);
		rd(`TSC_ADR_PERIOD, 8 * h);
		wb(1'h0, `TSC_ADR_STAT, 32'h0);
		chk(rdat[11:8], 0);
		wb(1'h1, `TSC_ADR_CEIL, 32'hF);
		wb(1'h1, `TSC_ADR_RELOAD, 32'h1F);
		wb(1'h1, `TSC_ADR_STAT, 32'h2);
		wv(20 * h);
		wb(1'h0, `TSC_ADR_STAT, 32'h0);
		chk(rdat[11:8], epsc(8 * h, 31, 15));
		wb(1'h1, `TSC_ADR_RELOAD, 32'hFF);
		for (int c = 1; c < 16; c++) begin
			h = ((nt[c] + 1) << dv[c]) + 2;
			half_q <= h;
			cfg(c[3:0], 4'h0);
			wv(16 * h);
			chk(valid, 1);
			half_q <= (nt[c] - 1) << dv[c];
			cfg(c[3:0], 4'h0);
			repeat (12 * (nt[c] << dv[c])) @(posedge clk_i);
			chk(valid, 0);
		end
		run <= 1'h0;
		wb(1'h1, `TSC_ADR_RELOAD, 32'hF);
		wb(1'h1, `TSC_ADR_AVG, 32'h00040104);
		cfg(4'h0, 4'h1);
		repeat (56) @(posedge clk_i);
		chk(fault, 0);
		repeat (16) @(posedge clk_i);
		chk(fault, 1);
		repeat (400) @(posedge clk_i);
		wb(1'h0, `TSC_ADR_STAT, 32'h0);
		chk(rdat[11:0], 12'h101);
		wb(1'h1, `TSC_ADR_CTRL, 32'h0);
		wb(1'h1, `TSC_ADR_STAT, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(fault, 0);
		final_report();
	end
endmodule // tb_top
`default_nettype wire
